// ---- common/gpio_lmn_cfg.svh ----
// Offsets, field positions, reset values and widths of the three port blocks.
// Assumes inclusion from the package and the design files by bare name.
`ifndef GPIO_LMN_CFG_SVH
`define GPIO_LMN_CFG_SVH
`define OFS_INPUT_PORT_PIN_LEVELS 12'h000
`define OFS_SIX_PIN_PORT_DATA 12'h004
`define OFS_EIGHT_PIN_PORT_DATA 12'h008
`define OFS_INPUT_PORT_MODE_CONTROL 12'h010
`define OFS_SIX_PIN_PORT_MODE_CONTROL 12'h014
`define OFS_EIGHT_PIN_PORT_MODE_CONTROL 12'h018
`define RST_DATA 8'h00
`define RST_MODE 16'h0000
`define SIX_PIN_VALID_MASK 8'h5F
`define SIX_PIN_NOFUNC_POS 4
`define ADDR_DECODE_BITS 12
`endif

// ---- common/gpio_lmn_pkg.sv ----
// Types shared by the port block and its pin cell.
// Assumes the constants header sits beside it.
`include "gpio_lmn_cfg.svh"
package gpio_lmn_pkg;
    typedef enum logic [1:0] {
        MODE_OTHER = 2'h0,
        MODE_OUTPUT = 2'h1,
        MODE_IN_PULLUP = 2'h2,
        MODE_IN_NOPULL = 2'h3
    } pin_mode_t;

    // Board-facing drive of one pin: value, enable, pull-up enable.
    typedef struct packed {
        logic dout;
        logic oe;
        logic pull_en;
    } pin_drive_t;

    typedef enum {
        BUS_IDLE,
        BUS_DATA
    } bus_state_t;
endpackage

// ---- design/gpio_pin_cell.sv ----
// One bidirectional pin: synchroniser, mode decode, read mux and drive.
// Assumes pin_in arrives asynchronously from the board.
`timescale 1ns/10ps
`default_nettype none
module gpio_pin_cell
    import gpio_lmn_pkg::*;
#(
    parameter bit NOFUNC_PIN = 1'b0
) (
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic pin_in,
    input wire logic [1:0] mode,
    input wire logic data_bit,
    output logic read_bit,
    output pin_drive_t drive
);
    logic sync1_r;
    logic sync2_r;

    // Two flip-flops before anything reads the pin level.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            sync1_r <= 1'b0;
            sync2_r <= 1'b0;
        end else begin
            sync1_r <= pin_in;
            sync2_r <= sync1_r;
        end
    end

    // Input modes read the pin, the others read the stored bit.
    always_comb begin
        read_bit = mode[1] ? sync2_r : data_bit;
    end

    // Only output mode drives the pin; the no-function pin never drives.
    always_comb begin
        drive.dout = data_bit;
        drive.oe = (mode == MODE_OUTPUT) && !NOFUNC_PIN;
        drive.pull_en = (mode == MODE_IN_PULLUP);
    end
endmodule
`default_nettype wire

// ---- design/gpio_lmn_data.sv ----
// Data registers of a four-pin input port, a six-pin and an eight-pin port.
// Assumes an AHB-Lite master with single word transfers; pins are async.
//
// Operation
// - Input port register: low four bits are pins.
// - Input port bits seven to four read zero.
// - Input mode read returns current pin level.
// - Input pins: 00 reads zero, 11 reads pin.
// - Six-pin register bits six, four..zero map pins.
// - Six-pin bits seven and five read zero.
// - Six-pin output mode reads stored bit.
// - Bidirectional input modes read sampled pin.
// - Six-pin modes: other, output, pull-up, plain input.
// - Six-pin pin four: no function, never drives.
// - Eight-pin register bits map eight pins.
// - Eight-pin output mode reads stored bit.
// - Eight-pin modes; non-output writes leave pins.
// - Each bidirectional pin has mode-driven pull-up.
//
// Local design decisions: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "gpio_lmn_cfg.svh"
module gpio_lmn_data
    import gpio_lmn_pkg::*;
(
    input wire logic clk_sys,
    input wire logic srst,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [3:0] input_pin_in,
    input wire logic [7:0] six_pin_in,
    output logic [7:0] six_pin_out,
    output logic [7:0] six_pin_oe,
    output logic [7:0] six_pin_pull_en,
    input wire logic [7:0] eight_pin_in,
    output logic [7:0] eight_pin_out,
    output logic [7:0] eight_pin_oe,
    output logic [7:0] eight_pin_pull_en
);
    logic [7:0] six_pin_port_data_r;
    logic [7:0] eight_pin_port_data_r;
    logic [7:0] input_port_mode_control_r;
    logic [15:0] six_pin_port_mode_control_r;
    logic [15:0] eight_pin_port_mode_control_r;
    logic [3:0] in_sync1_r;
    logic [3:0] in_sync2_r;
    logic [7:0] input_port_pin_levels;
    logic [7:0] six_read;
    logic [7:0] eight_read;
    pin_drive_t six_drive [8];
    pin_drive_t eight_drive [8];
    logic wr_pend_r;
    logic [11:0] wr_addr_r;
    logic [31:0] hrdata_r;
    bus_state_t state_r;
    logic addr_take;
    logic rd_stall;
    logic rd_again_r;

    // Word offset decode, shared by reads and writes.
    function automatic logic hit(input logic [11:0] a, input logic [11:0] ofs);
        hit = (a[11:2] == ofs[11:2]);
    endfunction

    // Input-only port: pins pass two flip-flops before the read mux.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            in_sync1_r <= 4'h0;
            in_sync2_r <= 4'h0;
        end else begin
            in_sync1_r <= input_pin_in;
            in_sync2_r <= in_sync1_r;
        end
    end

    // Mode 11 reads the pin, anything else reads zero; upper nibble is zero.
    always_comb begin
        input_port_pin_levels = 8'h00;
        for (int i = 0; i < 4; i++) begin
            input_port_pin_levels[i] =
                (input_port_mode_control_r[2*i +: 2] == MODE_IN_NOPULL)
                && in_sync2_r[i];
        end
    end

    // Per-pin cells; bits seven and five of the six-pin port are absent.
    genvar g;
    generate
        for (g = 0; g < 8; g++) begin : g_pins
            if (g != 7 && g != 5) begin : g_six
                gpio_pin_cell #(
                    .NOFUNC_PIN(g == `SIX_PIN_NOFUNC_POS)
                ) u_six (
                    .clk_sys(clk_sys),
                    .srst(srst),
                    .pin_in(six_pin_in[g]),
                    .mode(six_pin_port_mode_control_r[2*g +: 2]),
                    .data_bit(six_pin_port_data_r[g]),
                    .read_bit(six_read[g]),
                    .drive(six_drive[g])
                );
            end else begin : g_six_rsvd
                assign six_read[g] = 1'b0;
                assign six_drive[g] = '0;
            end
            gpio_pin_cell #(
                .NOFUNC_PIN(1'b0)
            ) u_eight (
                .clk_sys(clk_sys),
                .srst(srst),
                .pin_in(eight_pin_in[g]),
                .mode(eight_pin_port_mode_control_r[2*g +: 2]),
                .data_bit(eight_pin_port_data_r[g]),
                .read_bit(eight_read[g]),
                .drive(eight_drive[g])
            );
        end
    endgenerate

    // Registered pin drive, so every port output comes from a flip-flop.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            six_pin_out <= 8'h00;
            six_pin_oe <= 8'h00;
            six_pin_pull_en <= 8'h00;
            eight_pin_out <= 8'h00;
            eight_pin_oe <= 8'h00;
            eight_pin_pull_en <= 8'h00;
        end else begin
            for (int i = 0; i < 8; i++) begin
                six_pin_out[i] <= six_drive[i].dout;
                six_pin_oe[i] <= six_drive[i].oe;
                six_pin_pull_en[i] <= six_drive[i].pull_en;
                eight_pin_out[i] <= eight_drive[i].dout;
                eight_pin_oe[i] <= eight_drive[i].oe;
                eight_pin_pull_en[i] <= eight_drive[i].pull_en;
            end
        end
    end

    // An address phase is taken only for a selected NONSEQ or SEQ transfer.
    assign addr_take = hsel && hready && htrans[1];

    // Bus phase tracking; a wait state holds the phase and the address.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            state_r <= BUS_IDLE;
            wr_pend_r <= 1'b0;
            wr_addr_r <= 12'h000;
        end else begin
            if (hready) begin
                state_r <= addr_take ? BUS_DATA : BUS_IDLE;
                wr_pend_r <= addr_take && hwrite;
                wr_addr_r <= haddr[11:0];
            end
        end
    end

    // Write data lands in the data phase; six-pin data bits seven and five are masked off.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            six_pin_port_data_r <= `RST_DATA;
            eight_pin_port_data_r <= `RST_DATA;
            input_port_mode_control_r <= 8'h00;
            six_pin_port_mode_control_r <= `RST_MODE;
            eight_pin_port_mode_control_r <= `RST_MODE;
        end else if (wr_pend_r && state_r == BUS_DATA) begin
            if (hit(wr_addr_r, `OFS_SIX_PIN_PORT_DATA))
                six_pin_port_data_r <= hwdata[7:0] & `SIX_PIN_VALID_MASK;
            if (hit(wr_addr_r, `OFS_EIGHT_PIN_PORT_DATA))
                eight_pin_port_data_r <= hwdata[7:0];
            if (hit(wr_addr_r, `OFS_INPUT_PORT_MODE_CONTROL))
                input_port_mode_control_r <= hwdata[7:0];
            if (hit(wr_addr_r, `OFS_SIX_PIN_PORT_MODE_CONTROL))
                six_pin_port_mode_control_r <= hwdata[15:0];
            if (hit(wr_addr_r, `OFS_EIGHT_PIN_PORT_MODE_CONTROL))
                eight_pin_port_mode_control_r <= hwdata[15:0];
        end
    end

    // Read mux, shared by the address phase and the retry after a write.
    function automatic logic [31:0] read_word(input logic [11:0] a);
        if (hit(a, `OFS_INPUT_PORT_PIN_LEVELS))
            read_word = {24'h00_0000, input_port_pin_levels};
        else if (hit(a, `OFS_SIX_PIN_PORT_DATA))
            read_word = {24'h00_0000, six_read};
        else if (hit(a, `OFS_EIGHT_PIN_PORT_DATA))
            read_word = {24'h00_0000, eight_read};
        else if (hit(a, `OFS_INPUT_PORT_MODE_CONTROL))
            read_word = {24'h00_0000, input_port_mode_control_r};
        else if (hit(a, `OFS_SIX_PIN_PORT_MODE_CONTROL))
            read_word = {16'h0000, six_pin_port_mode_control_r};
        else if (hit(a, `OFS_EIGHT_PIN_PORT_MODE_CONTROL))
            read_word = {16'h0000, eight_pin_port_mode_control_r};
        else
            read_word = 32'h0000_0000;
    endfunction

    // A read whose address phase meets a write's data phase would capture
    // the old value, so it is stretched by one cycle and captured again.
    assign rd_stall = addr_take && !hwrite && wr_pend_r
        && state_r == BUS_DATA;

    // Read data is captured at the address phase and stands in the data
    // phase; unmapped words read zero.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hrdata_r <= 32'h0000_0000;
        end else if (rd_again_r) begin
            hrdata_r <= read_word(wr_addr_r);
        end else if (addr_take && !hwrite) begin
            hrdata_r <= read_word(haddr[11:0]);
        end
    end

    // Always OKAY; the only wait state is the one for a read behind a write.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            rd_again_r <= 1'b0;
        end else begin
            hreadyout <= !rd_stall;
            hresp <= 1'b0;
            rd_again_r <= rd_stall;
        end
    end
    assign hrdata = hrdata_r;

    // Checks next to the logic they guard.
    property p_in_upper_zero;
        @(posedge clk_sys) disable iff (srst)
        input_port_pin_levels[7:4] == 4'h0;
    endproperty
    a_in_upper_zero: assert property (p_in_upper_zero)
        else $error("input port upper nibble not zero");

    property p_in_other_zero;
        @(posedge clk_sys) disable iff (srst)
        (input_port_mode_control_r[1:0] == 2'h0)
        |-> !input_port_pin_levels[0];
    endproperty
    a_in_other_zero: assert property (p_in_other_zero)
        else $error("input pin in other mode not zero");

    property p_in_reads_pin;
        @(posedge clk_sys) disable iff (srst)
        (input_port_mode_control_r[3:2] == 2'h3)
        |-> input_port_pin_levels[1] == $past(input_pin_in[1], 2);
    endproperty
    a_in_reads_pin: assert property (p_in_reads_pin)
        else $error("input pin level not read back");

    property p_six_rsvd;
        @(posedge clk_sys) disable iff (srst)
        six_pin_port_data_r[7] == 1'b0 && six_pin_port_data_r[5] == 1'b0
        && six_read[7] == 1'b0 && six_read[5] == 1'b0;
    endproperty
    a_six_rsvd: assert property (p_six_rsvd)
        else $error("six-pin reserved bit set");

    property p_six_out_reads_reg;
        @(posedge clk_sys) disable iff (srst)
        (six_pin_port_mode_control_r[1:0] == 2'h1)
        |-> six_read[0] == six_pin_port_data_r[0];
    endproperty
    a_six_out_reads_reg: assert property (p_six_out_reads_reg)
        else $error("six-pin output read not register");

    property p_six_pin4_nodrive;
        @(posedge clk_sys) disable iff (srst)
        !six_pin_oe[4];
    endproperty
    a_six_pin4_nodrive: assert property (p_six_pin4_nodrive)
        else $error("six-pin pin four driven");

    property p_eight_drive;
        @(posedge clk_sys) disable iff (srst)
        (eight_pin_port_mode_control_r[15:14] == 2'h1) |=>
        eight_pin_oe[7] && eight_pin_out[7] == $past(eight_pin_port_data_r[7]);
    endproperty
    a_eight_drive: assert property (p_eight_drive)
        else $error("eight-pin output not driven");

    property p_eight_pull;
        @(posedge clk_sys) disable iff (srst)
        (eight_pin_port_mode_control_r[1:0] == 2'h2) |=>
        eight_pin_pull_en[0] && !eight_pin_oe[0];
    endproperty
    a_eight_pull: assert property (p_eight_pull)
        else $error("eight-pin pull-up not enabled");

    property p_reset_clear;
        @(posedge clk_sys) srst |=> eight_pin_port_data_r == 8'h00;
    endproperty
    a_reset_clear: assert property (p_reset_clear)
        else $error("data not cleared by reset");

    property p_rd_stall;
        @(posedge clk_sys) disable iff (srst)
        rd_stall |=> !hreadyout ##1 hreadyout;
    endproperty
    a_rd_stall: assert property (p_rd_stall)
        else $error("read behind write not stretched once");

    c_write: cover property (@(posedge clk_sys) wr_pend_r);
    c_stall: cover property (@(posedge clk_sys) rd_again_r);
    c_out: cover property (@(posedge clk_sys) eight_pin_oe[0]);
    c_in: cover property (@(posedge clk_sys) input_port_pin_levels[0]);
endmodule
`default_nettype wire

// ---- test/gpio_lmn_board.sv ----
// Board model for the port pins: resolves each pad from all drivers.
// Assumes the bench sets board levels and board drive enables.
`timescale 1ns/10ps
`default_nettype none
module gpio_lmn_board (
    input wire logic clk_sys,
    input wire logic [7:0] six_pin_out,
    input wire logic [7:0] six_pin_oe,
    input wire logic [7:0] six_pin_pull_en,
    input wire logic [7:0] eight_pin_out,
    input wire logic [7:0] eight_pin_oe,
    input wire logic [7:0] eight_pin_pull_en,
    input wire logic [3:0] brd_l,
    input wire logic [7:0] brd_m,
    input wire logic [7:0] brd_m_en,
    input wire logic [7:0] brd_n,
    input wire logic [7:0] brd_n_en,
    output logic [3:0] input_pin_in,
    output logic [7:0] six_pin_in,
    output logic [7:0] eight_pin_in
);
    logic [7:0] m_last_r = 8'h00;
    logic [7:0] n_last_r = 8'h00;

    // An undriven pad with no pull-up floats, so it toggles every cycle.
    function automatic logic pad(logic oe, d, en, b, pu, last);
        if (oe)
            return d;
        if (en)
            return b;
        return pu ? 1'b1 : ~last;
    endfunction

    // The chip's drive wins; the board lets go of a pad the chip drives.
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            six_pin_in[i] = pad(six_pin_oe[i], six_pin_out[i], brd_m_en[i],
                brd_m[i], six_pin_pull_en[i], m_last_r[i]);
            eight_pin_in[i] = pad(eight_pin_oe[i], eight_pin_out[i],
                brd_n_en[i], brd_n[i], eight_pin_pull_en[i], n_last_r[i]);
        end
    end

    // The input-only pins are always driven from the board.
    assign input_pin_in = brd_l;

    // Remember the last pad level to make the floating pattern.
    always_ff @(posedge clk_sys) begin
        m_last_r <= six_pin_in;
        n_last_r <= eight_pin_in;
    end
endmodule
`default_nettype wire

// ---- test/gpio_lmn_data_tb_top.sv ----
// Self-checking bench for the three port data registers.
// Assumes the board model file is compiled before this one.
`timescale 1ns/10ps
`default_nettype none
module gpio_lmn_data_tb_top;
    logic clk_sys = 1'b0;
    logic srst = 1'b1;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd_r;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h0;
    logic hreadyout, hresp;
    logic [3:0] brd_l = 4'h0, input_pin_in;
    logic [7:0] brd_m = 8'h0, brd_m_en = 8'hFF, brd_n = 8'h0;
    logic [7:0] brd_n_en = 8'hFF, six_pin_in, eight_pin_in;
    logic [7:0] six_pin_out, six_pin_oe, six_pin_pull_en;
    logic [7:0] eight_pin_out, eight_pin_oe, eight_pin_pull_en;
    int miscompares = 0;
    int checks_done = 0;
    int cycles = 0;

    // The clock runs at 40 MHz.
    always #12.5 clk_sys = ~clk_sys;

    gpio_lmn_data dut (.clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite,
        .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp,
        .input_pin_in, .six_pin_in, .six_pin_out, .six_pin_oe,
        .six_pin_pull_en, .eight_pin_in, .eight_pin_out, .eight_pin_oe,
        .eight_pin_pull_en);

    gpio_lmn_board board (.clk_sys, .six_pin_out, .six_pin_oe,
        .six_pin_pull_en, .eight_pin_out, .eight_pin_oe, .eight_pin_pull_en,
        .brd_l, .brd_m, .brd_m_en, .brd_n, .brd_n_en, .input_pin_in,
        .six_pin_in, .eight_pin_in);

    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    // A hang anywhere ends the run well past the expected run of under two hundred cycles.
    always @(posedge clk_sys) begin
        cycles++;
        if (cycles == 3000) begin
            miscompares++;
            conclude();
        end
    end

    // One single-word transfer; the slave's ready is awaited at each phase.
    task automatic bus(input logic wr, input logic [31:0] a, wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= wr;
        hsize <= 3'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd_r = hrdata;
    endtask

    // Write then read one word back to back; the read may be stretched.
    task automatic wr_rd(input logic [31:0] a, wd);
        @(posedge clk_sys);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'h2;
        hwrite <= 1'b1;
        hsize <= 3'h2;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hwrite <= 1'b0;
        hwdata <= wd;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        hsel <= 1'b0;
        htrans <= 2'h0;
        @(posedge clk_sys);
        while (hreadyout !== 1'b1) @(posedge clk_sys);
        rd_r = hrdata;
    endtask

    task automatic chk(input string n, input logic [31:0] e, g);
        checks_done++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic rd(input string n, input logic [31:0] a, e);
        bus(1'b0, a, 32'h0);
        chk(n, e, rd_r);
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask

    // Pads need an edge to drive and two to pass the synchroniser.
    task automatic settle;
        repeat (4) @(posedge clk_sys);
    endtask

    task automatic t_input;
        bus(1'b1, 32'h010, 32'hC3);
        brd_l <= 4'hF;
        settle();
        rd("in_mixed", 32'h000, 32'h09);
        bus(1'b1, 32'h010, 32'hFF);
        brd_l <= 4'hA;
        bus(1'b1, 32'h000, 32'hFF);
        settle();
        rd("in_pins", 32'h000, 32'h0A);
        bus(1'b1, 32'h010, 32'h00);
        rd("in_other", 32'h000, 32'h00);
        $display("test input port done");
    endtask

    task automatic t_six;
        bus(1'b1, 32'h004, 32'h5F);
        rd("six_reg", 32'h004, 32'h5F);
        chk("six_oe_off", 32'h0, {24'h0, six_pin_oe});
        bus(1'b1, 32'h014, 32'h1055);
        settle();
        chk("six_oe", 32'h4F, {24'h0, six_pin_oe});
        chk("six_out", 32'h4F, {24'h0, six_pin_out & 8'h4F});
        rd("six_outrd", 32'h004, 32'h5F);
        bus(1'b1, 32'h014, 32'h22AA);
        brd_m_en <= 8'h00;
        settle();
        chk("six_pull", 32'h5F, {24'h0, six_pin_pull_en});
        rd("six_pullrd", 32'h004, 32'h5F);
        bus(1'b1, 32'h014, 32'h33FF);
        brd_m_en <= 8'hFF;
        brd_m <= 8'hAA;
        settle();
        rd("six_inrd", 32'h004, 32'h0A);
        $display("test six-pin port done");
    endtask

    task automatic t_eight;
        bus(1'b1, 32'h008, 32'hA5);
        rd("n_reg", 32'h008, 32'hA5);
        chk("n_oe_off", 32'h0, {24'h0, eight_pin_oe});
        bus(1'b1, 32'h018, 32'h5555);
        bus(1'b1, 32'h008, 32'h5A);
        settle();
        chk("n_drive", 32'hFF5A, {eight_pin_oe, eight_pin_out});
        rd("n_outrd", 32'h008, 32'h5A);
        wr_rd(32'h008, 32'hC3);
        chk("n_wr_rd", 32'hC3, rd_r);
        bus(1'b1, 32'h018, 32'hAAAA);
        brd_n_en <= 8'h00;
        settle();
        chk("n_pull", 32'hFF, {24'h0, eight_pin_pull_en});
        rd("n_pullrd", 32'h008, 32'hFF);
        bus(1'b1, 32'h018, 32'hFFFF);
        brd_n_en <= 8'hFF;
        brd_n <= 8'h3C;
        settle();
        rd("n_inrd", 32'h008, 32'h3C);
        $display("test eight-pin port done");
    endtask

    // Reset is held for 20 cycles, then every scenario runs once.
    initial begin
        repeat (20) @(posedge clk_sys);
        srst <= 1'b0;
        rd("in_rst", 32'h000, 32'h0);
        rd("six_rst", 32'h004, 32'h0);
        rd("n_rst", 32'h008, 32'h0);
        chk("oe_rst", 32'h0, {16'h0, six_pin_oe, eight_pin_oe});
        rd("unmapped", 32'h020, 32'h0);
        $display("test reset done");
        t_input();
        t_six();
        t_eight();
        conclude();
    end
endmodule
`default_nettype wire
